// >>> hw/stack_queue_consts.svh
// offsets, opcodes, field positions and reset values of the stack and queue executor
`ifndef STACK_QUEUE_CONSTS_SVH
`define STACK_QUEUE_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets and bank count
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_OPCODE    8'h04
`define OFS_OPERAND   8'h08
`define OFS_MASK      8'h0c
`define OFS_STATUS    8'h10
`define OFS_RESULT    8'h14
`define OFS_PC        8'h18
`define OFS_PSTAT     8'h1c
`define OFS_TRAP_LVL  8'h20
`define OFS_GPR_BASE  8'h40
`define OFS_BANK_BASE 8'h80
`define BANK_COUNT    5
// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OP_PUSH_BYTE_ADDR  16'h009f
`define OP_PUSH_WORD_ADDR  16'h003f
`define OP_PUSH_LONG_ADDR  16'h00df
`define OP_PUSH_QUAD_ADDR  16'h007f
`define OP_PUSH_OCTA_ADDR  16'h7ffd
`define OP_PUSH_LONG_VALUE 16'h00dd
`define OP_PUSH_REG_SET    16'h00bb
`define OP_QUEUE_REMOVE    16'h000f
`define OP_REMOVE_HEAD_LK  16'h005e
`define OP_REMOVE_TAIL_LK  16'h005f
`define OP_EXC_RETURN      16'h0002
// ----------------------------------------------------------------
// machine constants
// ----------------------------------------------------------------
`define SP_INDEX       4'he
`define MASK_TOP_BIT   4'he
`define LONG_BYTES     32'h0000_0004
`define BLINK_OFS      32'h0000_0004
`define POP_PAIR_BYTES 32'h0000_0008
`define TRAP_NONE      3'h4
// ----------------------------------------------------------------
// processor status longword fields
// ----------------------------------------------------------------
`define PS_ISTK_BIT    26
`define PS_CUR_HI      25
`define PS_CUR_LO      24
`define PS_PRV_HI      23
`define PS_PRV_LO      22
`define PS_MBZ_MASK    32'h3820_ff00
`define PS_RESET       32'h041f_0000
// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define ST_BUSY        0
`define ST_DONE        1
`define ST_V           2
`define ST_Z           3
`define ST_MM_FAULT    4
`define ST_BAD_PS      5
`define ST_BAD_OP      6
`define ST_TRAP_DLV    7
`define ST_LOCK_FAIL   8
`endif

// >>> hw/stack_queue_pkg.sv
// types shared by the stack and queue executor
package stack_queue_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_PUSH, S_SCAN, S_LOCK, S_RD_HDR, S_RD_F, S_RD_B,
    S_PRB_B, S_PRB_F, S_WR_B, S_WR_F, S_POP_PC, S_POP_PS, S_RET_CHK
  } exec_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        probe;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } mem_rsp_t;
endpackage

// >>> hw/stack_queue_exec.sv
// stack push, queue removal and exception return executor with axi4-lite registers
`timescale 1ns/1ps
`include "stack_queue_consts.svh"

module stack_queue_exec
  import stack_queue_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // memory port
  output mem_req_t         mem_req,
  input  wire mem_rsp_t    mem_rsp,
  // secondary interlock
  output logic             lock_req,
  input  wire logic        lock_grant,
  input  wire logic        lock_fail,
  // processor side
  output logic             intr_inhibit,
  output logic             prefetch_flush
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  exec_state_t st_q;
  mem_req_t    mem_q;
  logic [31:0] gpr_q [16];
  logic [31:0] bank_q [`BANK_COUNT];
  logic [15:0] opcode_q;
  logic [31:0] operand_q;
  logic [15:0] mask_q;
  logic [31:0] status_q;
  logic [31:0] result_q;
  logic [31:0] pc_q;
  logic [31:0] pstat_q;
  logic [2:0]  trap_lvl_q;
  logic [31:0] tmp_q;
  logic [31:0] tmp_pc_q;
  logic [31:0] ent_q;
  logic [31:0] hdr_q;
  logic [31:0] flink_q;
  logic [31:0] blink_q;
  logic [3:0]  idx_q;
  logic        is_rset_q;
  logic        is_tail_q;
  logic        is_locked_q;
  logic        lock_req_q;
  logic        inhibit_q;
  logic        flush_q;
  // axi
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  logic        wr_fire;
  logic        wr_ok;
  logic [31:0] wr_val;
  logic        start;
  logic [31:0] sp;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [2:0]  old_idx;
  logic [2:0]  new_idx;
  logic        pstat_good;

  assign sp      = gpr_q[`SP_INDEX];
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign start   = wr_fire && awaddr_q == `OFS_CTRL && wr_val[0] && st_q == S_IDLE;

  // byte-lane merge against the current register value
  always_comb
  begin
    wr_val = rd_val;
    for (int b = 0; b < 4; b++)
      if (wstrb_q[b])
        wr_val[8*b +: 8] = wdata_q[8*b +: 8];
  end

  // ----------------------------------------------------------------
  // register read mux, also serves the write merge
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] a;
    a      = wr_fire ? awaddr_q : s_axi_araddr;
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (a >= `OFS_GPR_BASE && a < `OFS_BANK_BASE)
      rd_val = gpr_q[a[5:2]];
    else if (a >= `OFS_BANK_BASE && a[6:2] < 5'(`BANK_COUNT) && a[7])
      rd_val = bank_q[a[4:2]];
    else
      case (a)
        `OFS_CTRL:      rd_val = 32'h0000_0000;
        `OFS_OPCODE:    rd_val = {16'h0000, opcode_q};
        `OFS_OPERAND:   rd_val = operand_q;
        `OFS_MASK:      rd_val = {16'h0000, mask_q};
        `OFS_STATUS:    rd_val = status_q;
        `OFS_RESULT:    rd_val = result_q;
        `OFS_PC:        rd_val = pc_q;
        `OFS_PSTAT:     rd_val = pstat_q;
        `OFS_TRAP_LVL:  rd_val = {29'h0000_0000, trap_lvl_q};
        default:        rd_ok  = 1'b0;
      endcase
  end

  // ----------------------------------------------------------------
  // axi4-lite channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // reads wait while a write is being committed, so the mux serves one at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'h0;
    end
    else if (rvalid_q)
    begin
      if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
    else if (s_axi_arvalid && !wr_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_ok ? 2'h0 : 2'h2;
    end
  end

  assign wr_ok = rd_ok && awaddr_q != `OFS_STATUS;

  // ----------------------------------------------------------------
  // execution engine and software-visible state
  // ----------------------------------------------------------------
  task automatic issue(input logic w, input logic p, input logic [31:0] ad, input logic [31:0] d);
    mem_q.valid <= 1'b1;
    mem_q.write <= w;
    mem_q.probe <= p;
    mem_q.addr  <= ad;
    mem_q.wdata <= d;
  endtask

  // new status is accepted only if it does not raise privilege and is self-consistent
  always_comb
  begin
    old_idx    = pstat_q[`PS_ISTK_BIT] ? 3'h4 : {1'b0, pstat_q[`PS_CUR_HI:`PS_CUR_LO]};
    new_idx    = tmp_q[`PS_ISTK_BIT] ? 3'h4 : {1'b0, tmp_q[`PS_CUR_HI:`PS_CUR_LO]};
    pstat_good = (tmp_q & `PS_MBZ_MASK) == 32'h0000_0000
              && tmp_q[`PS_CUR_HI:`PS_CUR_LO] >= pstat_q[`PS_CUR_HI:`PS_CUR_LO]
              && tmp_q[`PS_PRV_HI:`PS_PRV_LO] >= tmp_q[`PS_CUR_HI:`PS_CUR_LO]
              && !(tmp_q[`PS_ISTK_BIT] && tmp_q[`PS_CUR_HI:`PS_CUR_LO] != 2'h0);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q        <= S_IDLE;
      mem_q       <= '0;
      for (int i = 0; i < 16; i++)
        gpr_q[i] <= 32'h0000_0000;
      for (int i = 0; i < `BANK_COUNT; i++)
        bank_q[i] <= 32'h0000_0000;
      opcode_q    <= 16'h0000;
      operand_q   <= 32'h0000_0000;
      mask_q      <= 16'h0000;
      status_q    <= 32'h0000_0000;
      result_q    <= 32'h0000_0000;
      pc_q        <= 32'h0000_0000;
      pstat_q     <= `PS_RESET;
      trap_lvl_q  <= `TRAP_NONE;
      tmp_q       <= 32'h0000_0000;
      tmp_pc_q    <= 32'h0000_0000;
      ent_q       <= 32'h0000_0000;
      hdr_q       <= 32'h0000_0000;
      flink_q     <= 32'h0000_0000;
      blink_q     <= 32'h0000_0000;
      idx_q       <= 4'h0;
      is_rset_q   <= 1'b0;
      is_tail_q   <= 1'b0;
      is_locked_q <= 1'b0;
      lock_req_q  <= 1'b0;
      inhibit_q   <= 1'b0;
      flush_q     <= 1'b0;
    end
    else
    begin
      flush_q <= 1'b0;
      // software writes land only while the engine is idle
      if (wr_fire && wr_ok && st_q == S_IDLE)
      begin
        if (awaddr_q >= `OFS_GPR_BASE && awaddr_q < `OFS_BANK_BASE)
          gpr_q[awaddr_q[5:2]] <= wr_val;
        else if (awaddr_q[7])
          bank_q[awaddr_q[4:2]] <= wr_val;
        else
          case (awaddr_q)
            `OFS_OPCODE:    opcode_q    <= wr_val[15:0];
            `OFS_OPERAND:   operand_q   <= wr_val;
            `OFS_MASK:      mask_q      <= wr_val[15:0];
            `OFS_RESULT:    result_q    <= wr_val;
            `OFS_PC:        pc_q        <= wr_val;
            `OFS_PSTAT:     pstat_q     <= wr_val;
            `OFS_TRAP_LVL:  trap_lvl_q  <= wr_val[2:0];
            default:        ;
          endcase
      end
      // a memory fault ends any sequence; validation runs first, so links stay intact
      if (mem_q.valid && mem_rsp.ack && mem_rsp.err)
      begin
        mem_q.valid           <= 1'b0;
        status_q[`ST_MM_FAULT] <= 1'b1;
        status_q[`ST_BUSY]    <= 1'b0;
        status_q[`ST_DONE]    <= 1'b1;
        lock_req_q            <= 1'b0;
        inhibit_q             <= 1'b0;
        st_q                  <= S_IDLE;
      end
      else
        case (st_q)
          S_IDLE:
          if (start)
          begin
            status_q           <= 32'h0000_0000;
            status_q[`ST_BUSY] <= 1'b1;
            is_rset_q          <= 1'b0;
            is_locked_q        <= 1'b0;
            is_tail_q          <= opcode_q == `OP_REMOVE_TAIL_LK;
            case (opcode_q)
              `OP_PUSH_BYTE_ADDR, `OP_PUSH_WORD_ADDR, `OP_PUSH_LONG_ADDR,
              `OP_PUSH_QUAD_ADDR, `OP_PUSH_OCTA_ADDR, `OP_PUSH_LONG_VALUE:
              begin
                tmp_q <= operand_q;
                st_q  <= S_PUSH;
              end
              `OP_PUSH_REG_SET:
              begin
                is_rset_q  <= 1'b1;
                idx_q      <= `MASK_TOP_BIT;
                st_q       <= S_SCAN;
              end
              `OP_QUEUE_REMOVE:
              begin
                ent_q <= operand_q;
                st_q  <= S_RD_F;
              end
              `OP_REMOVE_HEAD_LK, `OP_REMOVE_TAIL_LK:
              begin
                hdr_q       <= operand_q;
                is_locked_q <= 1'b1;
                lock_req_q  <= 1'b1;
                st_q        <= S_LOCK;
              end
              `OP_EXC_RETURN:
                st_q <= S_POP_PC;
              default:
              begin
                status_q[`ST_BAD_OP] <= 1'b1;
                status_q[`ST_BUSY]   <= 1'b0;
                status_q[`ST_DONE]   <= 1'b1;
              end
            endcase
          end
          S_PUSH:
          if (!mem_q.valid)
            issue(1'b1, 1'b0, sp - `LONG_BYTES, tmp_q);
          else if (mem_rsp.ack)
          begin
            mem_q.valid       <= 1'b0;
            gpr_q[`SP_INDEX]  <= sp - `LONG_BYTES;
            if (is_rset_q && idx_q != 4'h0)
            begin
              idx_q <= idx_q - 4'h1;
              st_q  <= S_SCAN;
            end
            else
            begin
              status_q[`ST_BUSY] <= 1'b0;
              status_q[`ST_DONE] <= 1'b1;
              st_q               <= S_IDLE;
            end
          end
          S_SCAN:
          if (mask_q[idx_q])
          begin
            // the stack pointer value pushed is the one current at that moment
            tmp_q <= idx_q == `SP_INDEX ? sp : gpr_q[idx_q];
            st_q  <= S_PUSH;
          end
          else if (idx_q == 4'h0)
          begin
            status_q[`ST_BUSY] <= 1'b0;
            status_q[`ST_DONE] <= 1'b1;
            st_q               <= S_IDLE;
          end
          else
            idx_q <= idx_q - 4'h1;
          S_LOCK:
          if (lock_fail)
          begin
            lock_req_q             <= 1'b0;
            status_q[`ST_V]        <= 1'b1;
            status_q[`ST_Z]        <= 1'b0;
            status_q[`ST_LOCK_FAIL] <= 1'b1;
            status_q[`ST_BUSY]     <= 1'b0;
            status_q[`ST_DONE]     <= 1'b1;
            st_q                   <= S_IDLE;
          end
          else if (lock_grant)
            st_q <= S_RD_HDR;
          S_RD_HDR:
          if (!mem_q.valid)
            issue(1'b0, 1'b0, is_tail_q ? hdr_q + `BLINK_OFS : hdr_q, 32'h0000_0000);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            ent_q       <= mem_rsp.rdata;
            if (mem_rsp.rdata == hdr_q)
            begin
              lock_req_q         <= 1'b0;
              status_q[`ST_V]    <= 1'b1;
              status_q[`ST_Z]    <= 1'b1;
              status_q[`ST_BUSY] <= 1'b0;
              status_q[`ST_DONE] <= 1'b1;
              st_q               <= S_IDLE;
            end
            else
              st_q <= S_RD_F;
          end
          S_RD_F:
          if (!mem_q.valid)
            issue(1'b0, 1'b0, ent_q, 32'h0000_0000);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            flink_q     <= mem_rsp.rdata;
            // a self-linked entry is an empty header: nothing to take
            if (!is_locked_q && mem_rsp.rdata == ent_q)
            begin
              status_q[`ST_V]    <= 1'b1;
              status_q[`ST_Z]    <= 1'b1;
              status_q[`ST_BUSY] <= 1'b0;
              status_q[`ST_DONE] <= 1'b1;
              st_q               <= S_IDLE;
            end
            else
              st_q <= S_RD_B;
          end
          S_RD_B:
          if (!mem_q.valid)
            issue(1'b0, 1'b0, ent_q + `BLINK_OFS, 32'h0000_0000);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            blink_q     <= mem_rsp.rdata;
            st_q        <= S_PRB_B;
          end
          S_PRB_B:
          if (!mem_q.valid)
            issue(1'b1, 1'b1, blink_q, 32'h0000_0000);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            st_q        <= S_PRB_F;
          end
          S_PRB_F:
          if (!mem_q.valid)
            issue(1'b1, 1'b1, flink_q + `BLINK_OFS, 32'h0000_0000);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            inhibit_q   <= 1'b1;
            st_q        <= S_WR_B;
          end
          S_WR_B:
          if (!mem_q.valid)
            issue(1'b1, 1'b0, blink_q, flink_q);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            st_q        <= S_WR_F;
          end
          S_WR_F:
          if (!mem_q.valid)
            issue(1'b1, 1'b0, flink_q + `BLINK_OFS, blink_q);
          else if (mem_rsp.ack)
          begin
            mem_q.valid        <= 1'b0;
            inhibit_q          <= 1'b0;
            lock_req_q         <= 1'b0;
            result_q           <= ent_q;
            status_q[`ST_V]    <= 1'b0;
            status_q[`ST_Z]    <= flink_q == blink_q;
            status_q[`ST_BUSY] <= 1'b0;
            status_q[`ST_DONE] <= 1'b1;
            st_q               <= S_IDLE;
          end
          S_POP_PC:
          if (!mem_q.valid)
            issue(1'b0, 1'b0, sp, 32'h0000_0000);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            tmp_pc_q    <= mem_rsp.rdata;
            st_q        <= S_POP_PS;
          end
          S_POP_PS:
          if (!mem_q.valid)
            issue(1'b0, 1'b0, sp + `LONG_BYTES, 32'h0000_0000);
          else if (mem_rsp.ack)
          begin
            mem_q.valid <= 1'b0;
            tmp_q       <= mem_rsp.rdata;
            st_q        <= S_RET_CHK;
          end
          S_RET_CHK:
          begin
            status_q[`ST_BUSY] <= 1'b0;
            status_q[`ST_DONE] <= 1'b1;
            st_q               <= S_IDLE;
            if (!pstat_good)
              status_q[`ST_BAD_PS] <= 1'b1;
            else
            begin
              bank_q[old_idx] <= sp + `POP_PAIR_BYTES;
              gpr_q[`SP_INDEX] <= old_idx == new_idx ? sp + `POP_PAIR_BYTES : bank_q[new_idx];
              pstat_q         <= tmp_q;
              pc_q            <= tmp_pc_q;
              flush_q         <= 1'b1;
              status_q[`ST_TRAP_DLV] <= trap_lvl_q != `TRAP_NONE
                && {1'b0, tmp_q[`PS_CUR_HI:`PS_CUR_LO]} >= trap_lvl_q;
            end
          end
          default:
            st_q <= S_IDLE;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready  = !aw_have_q;
  assign s_axi_wready   = !w_have_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = !rvalid_q && !wr_fire;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign mem_req        = mem_q;
  assign lock_req       = lock_req_q;
  assign intr_inhibit   = inhibit_q;
  assign prefetch_flush = flush_q;
endmodule

// >>> test/stack_queue_exec_properties.sv
// port assertions for the stack and queue executor
`timescale 1ns/1ps
module stack_queue_exec_properties
  import stack_queue_pkg::*;
(
  // clock, reset and bus
  input wire logic     aclk,
  input wire logic     aresetn,
  input wire logic     s_axi_arvalid,
  input wire logic     s_axi_arready,
  input wire logic     s_axi_rvalid,
  input wire logic     s_axi_bvalid,
  input wire logic     s_axi_bready,
  // memory and processor side
  input wire mem_req_t mem_req,
  input wire mem_rsp_t mem_rsp,
  input wire logic     lock_req,
  input wire logic     lock_fail,
  input wire logic     intr_inhibit,
  input wire logic     prefetch_flush
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_req_hold; mem_req.valid && !mem_rsp.ack |=> mem_req.valid && $stable(mem_req); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  // a link write with interrupts open could leave a half-unlinked queue
  property p_inhibit; lock_req && mem_req.valid && mem_req.write && !mem_req.probe |-> intr_inhibit; endproperty
  a_inhibit: assert property (p_inhibit) else $error("link write not shielded");
  property p_fail; lock_req && lock_fail |=> !mem_req.valid [*2]; endproperty
  a_fail: assert property (p_fail) else $error("memory touched after lock failure");
  property p_lock_span; $fell(lock_req) |-> !mem_req.valid; endproperty
  a_lock_span: assert property (p_lock_span) else $error("lock dropped mid access");
  property p_flush; prefetch_flush |=> !prefetch_flush; endproperty
  a_flush: assert property (p_flush) else $error("flush not a pulse");
  property p_probe_err; mem_req.valid && mem_req.probe && mem_rsp.ack && mem_rsp.err |=> !mem_req.valid [*3]; endproperty
  a_probe_err: assert property (p_probe_err) else $error("access after failed check");
endmodule

// >>> test/stack_queue_mem_model.sv
// memory and interlock model; addresses 0x300-0x3ff fault
`timescale 1ns/1ps
module stack_queue_mem_model
  import stack_queue_pkg::*;
(
  // clock and reset
  input  wire logic     aclk,
  input  wire logic     aresetn,
  // memory and interlock
  input  wire mem_req_t mem_req,
  output mem_rsp_t      mem_rsp,
  input  wire logic     lock_req,
  output logic          lock_grant,
  output logic          lock_fail,
  // scenario control
  input  wire logic     slow,
  input  wire logic     deny
);
  logic [31:0] mem [256];
  logic        wt;
  wire         bad = mem_req.addr[9:8] == 2'b11;
  always @(posedge aclk)
  begin
    // idle data toggles so a stale value never looks valid
    mem_rsp.ack <= 1'b0;
    mem_rsp.rdata <= ~mem_rsp.rdata;
    lock_grant <= lock_req && !deny;
    lock_fail <= lock_req && deny;
    wt <= 1'b0;
    if (!aresetn)
      mem_rsp <= '0;
    else if (mem_req.valid && !mem_rsp.ack && slow && !wt)
      wt <= 1'b1;
    else if (mem_req.valid && !mem_rsp.ack)
    begin
      mem_rsp.ack <= 1'b1;
      mem_rsp.err <= bad;
      mem_rsp.rdata <= mem[mem_req.addr[9:2]];
      if (mem_req.write && !mem_req.probe && !bad)
        mem[mem_req.addr[9:2]] <= mem_req.wdata;
    end
  end
endmodule

// >>> test/stack_queue_exec_tb_top.sv
// bench for the stack and queue executor
`timescale 1ns/1ps
`include "stack_queue_consts.svh"
module stack_queue_exec_tb_top
  import stack_queue_pkg::*;
;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, bready = 0, rready = 0, slow = 0, deny = 0, fl = 0;
  logic awr, wrd, bv, arr, rv, lock_req, lock_grant, lock_fail, prefetch_flush;
  logic [7:0] aa = 0;
  logic [31:0] wd = 0, rdat, q, st;
  logic [1:0] br, rr, r;
  logic [15:0] ops [5] = '{16'h009f, 16'h003f, 16'h00df, 16'h007f, 16'h7ffd};
  int num_errors = 0, check_count = 0, i;
  mem_req_t mem_req;
  mem_rsp_t mem_rsp;
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (prefetch_flush === 1'b1) fl <= 1'b1;
  stack_queue_exec uut (.aclk, .aresetn, .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .mem_req, .mem_rsp,
    .lock_req, .lock_grant, .lock_fail, .intr_inhibit(), .prefetch_flush);
  stack_queue_mem_model mdl (.aclk, .aresetn, .mem_req, .mem_rsp, .lock_req, .lock_grant, .lock_fail, .slow, .deny);
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // ready and answer are sampled mid-cycle, acted on at the next rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    @(posedge aclk);
    aa <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    bready <= w;
    rready <= !w;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ha = w ? awr : arr;
      hw = wrd;
      hb = w ? bv : rv;
      q = rdat;
      r = w ? br : rr;
      @(posedge aclk);
      if (ha) awv <= 0;
      if (ha) arv <= 0;
      if (hw) wv <= 0;
      if (hb === 1'b1) break;
    end
    bready <= 0;
    rready <= 0;
    if (n == 40) chk(32'h0, 32'h1);
    if (n == 40) wrap_up();
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    xfer(1, a, d);
    chk({30'h0, r}, 32'h0);
  endtask
  task automatic run(input logic [15:0] op, input logic [31:0] opd, input logic [31:0] est);
    int n;
    wreg(`OFS_OPCODE, {16'h0, op});
    wreg(`OFS_OPERAND, opd);
    wreg(`OFS_CTRL, 32'h1);
    // start clears done, so a stale status word from an earlier run cannot end the poll
    st = 32'h0;
    for (n = 0; n < 60 && st[1] !== 1'b1; n++)
    begin
      xfer(0, `OFS_STATUS, 0);
      st = q;
    end
    if (n == 60) chk(32'h0, 32'h1);
    chk(st, est);
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    xfer(0, 8'hfc, 0);
    chk({30'h0, r}, 32'h2);
    xfer(1, `OFS_STATUS, 0);
    chk({30'h0, r}, 32'h2);
    wreg(8'h78, 32'h100);
    for (i = 0; i < 5; i++) run(ops[i], 32'h300, 32'h2);
    for (i = 0; i < 5; i++) chk(mdl.mem[63-i], 32'h300);
    run(16'h00dd, 32'hcafe0001, 32'h2);
    chk(mdl.mem[8'h3a], 32'hcafe0001);
    wreg(8'h40, 32'ha0);
    wreg(8'h48, 32'ha2);
    wreg(`OFS_MASK, 32'h8005);
    run(16'h00bb, 0, 32'h2);
    chk(mdl.mem[8'h39], 32'ha2);
    chk(mdl.mem[8'h38], 32'ha0);
    mdl.mem[8'h80] = 32'h210;
    mdl.mem[8'h81] = 32'h220;
    mdl.mem[8'h84] = 32'h220;
    mdl.mem[8'h85] = 32'h200;
    mdl.mem[8'h88] = 32'h200;
    mdl.mem[8'h89] = 32'h210;
    slow <= 1;
    run(16'h000f, 32'h210, 32'h2);
    chk(mdl.mem[8'h80], 32'h220);
    chk(mdl.mem[8'h89], 32'h200);
    xfer(0, `OFS_RESULT, 0);
    chk(q, 32'h210);
    run(16'h005f, 32'h200, 32'ha);
    xfer(0, `OFS_RESULT, 0);
    chk(q, 32'h220);
    run(16'h005e, 32'h200, 32'he);
    deny <= 1;
    run(16'h005e, 32'h200, 32'h106);
    mdl.mem[8'h84] = 32'h300;
    run(16'h000f, 32'h210, 32'h12);
    chk(mdl.mem[8'h80], 32'h200);
    mdl.mem[8'h38] = 32'h500;
    mdl.mem[8'h39] = 32'h0;
    wreg(8'h80, 32'h180);
    wreg(`OFS_TRAP_LVL, 32'h0);
    run(16'h0002, 0, 32'h82);
    xfer(0, `OFS_PC, 0);
    chk(q, 32'h500);
    chk({31'h0, fl}, 32'h1);
    xfer(0, 8'h90, 0);
    chk(q, 32'he8);
    xfer(0, 8'h78, 0);
    chk(q, 32'h180);
    wrap_up();
  end
endmodule
bind stack_queue_exec stack_queue_exec_properties chk_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .mem_req, .mem_rsp, .lock_req, .lock_fail, .intr_inhibit,
  .prefetch_flush);
